// *** verilog/halt_wakeup_pkg.sv ***
// How it works
// R1: halt enters timed wake-up only if wake enable set, rtc irq enable clear
// R2: in timed halt, rc oscillator runs through fixed divider then prescaler
// R3: halt lasts 64 times prescaler rc periods plus rc start-up time
// R4: on expiry hardware sets wake flag and raises wake interrupt ending halt
// R5: on wake main oscillator restarts, 256 or 4096 cycle stabilisation
// R6: reading control/status clears wake flag and its pending interrupt
// R7: measure bit in run mode enables rc, routes it to timer capture one
// R8: timed halt also ends on reset or any halt-exit interrupt
// R9: entering halt forces interrupt mask bits to 10b
// R10: in halt main oscillator stopped, only other-clocked peripherals run
// R11: watchdog-halt option may give watchdog reset instead of halt
// R12: control/status resets 00h, bit 2 read only, bits 7:3 read zero
// R13: wake enable bit 0 changed only by software
// R14: prescaler 8 bits, resets FFh, value n divides by n
// R15: software must not write prescaler 00h; such a write is ignored
// R16: ordinary halt requires wake enable clear and rtc irq enable clear
// R17: delay counter restarts each halt, stops with rc off on wake or disable
package halt_wakeup_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ctrl_status_offset = 8'h2B;
  localparam logic [7:0] prescaler_offset = 8'h2C;
  localparam logic [7:0] irq_mask_offset = 8'h2D;
  localparam logic [7:0] ctrl_status_reset = 8'h00;
  localparam logic [7:0] prescaler_reset = 8'hFF;
  localparam logic [7:0] irq_mask_reset = 8'h00;
  localparam int enable_bit = 0;
  localparam int measure_bit = 1;
  localparam int flag_bit = 2;
  // ==========================================================
  // timing
  localparam int fixed_divider = 64;
  localparam int clock_mhz = 50;
  localparam int rc_startup_ns = 2000;
  localparam int rc_startup_cycles = (rc_startup_ns * clock_mhz + 999) / 1000;
  localparam int stab_short_cycles = 256;
  localparam int stab_long_cycles = 4096;
  localparam logic [1:0] halt_irq_mask = 2'h2;
endpackage : halt_wakeup_pkg

// *** verilog/rc_edge_sync.sv ***
`timescale 1ns/10ps
// ==========================================================
// two-stage synchroniser with rising-edge pulse
module rc_edge_sync
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);
  logic stage_one;
  logic stage_two;
  logic stage_old;

  // first stage read only by second stage
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      stage_one <= 1'b0;
      stage_two <= 1'b0;
      stage_old <= 1'b0;
    end
    else
    begin
      stage_one <= async_in;
      stage_two <= stage_one;
      stage_old <= stage_two;
    end
  end

  assign level_out = stage_two;
  assign rise_out = stage_two & ~stage_old;
endmodule : rc_edge_sync

// *** verilog/halt_wakeup.sv ***
`timescale 1ns/10ps
// ==========================================================
// timed halt wake-up unit: registers, halt sequencer, rc delay count
module halt_wakeup
#(
  parameter int stab_long_count = halt_wakeup_pkg::stab_long_cycles
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  input wire logic halt_exec_in,
  input wire logic rtc_interrupt_enable_in,
  input wire logic watchdog_enabled_in,
  input wire logic watchdog_halt_option_in,
  input wire logic halt_exit_irq_in,
  input wire logic long_stab_in,
  input wire logic rc_clk_in,
  output logic rc_osc_enable_out,
  output logic timer_capture_input_one_out,
  output logic main_osc_enable_out,
  output logic cpu_halted_out,
  output logic cpu_resume_out,
  output logic watchdog_reset_out,
  output logic force_mask_out,
  output logic [1:0] condition_code_mask_out
);
  typedef enum logic [4:0]
  {
    st_run = 5'b00001,
    st_timed_halt = 5'b00010,
    st_plain_halt = 5'b00100,
    st_stabilise = 5'b01000,
    st_resume = 5'b10000
  } mode_t;

  mode_t mode;
  mode_t next_mode;
  logic timed_wake_enable;
  logic rc_measure_enable;
  logic wake_event_flag;
  logic [7:0] wake_prescale_value;
  logic [7:0] irq_mask;
  logic [5:0] fixed_count;
  logic [7:0] prescale_count;
  logic [15:0] startup_count;
  logic [12:0] stab_count;
  logic rc_level;
  logic rc_rise;
  logic rc_ready;
  logic delay_done;
  logic [7:0] status_view;
  logic [12:0] stab_limit;

  // ==========================================================
  // rc clock sampling
  rc_edge_sync rc_sync
  (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .async_in(rc_clk_in),
    .level_out(rc_level),
    .rise_out(rc_rise)
  );

  function automatic logic hit(input logic [7:0] addr,
    input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  // fixed divider of 64 then prescaler: count rc rising edges
  assign delay_done = rc_ready && rc_rise && (fixed_count == 6'h3F)
    && (prescale_count == wake_prescale_value - 8'h01);  // [R3]
  assign status_view = {5'h00, wake_event_flag, rc_measure_enable,
    timed_wake_enable};  // [R12]
  assign stab_limit = long_stab_in ? 13'(stab_long_count - 1)
    : 13'(halt_wakeup_pkg::stab_short_cycles - 1);

  // ==========================================================
  // halt sequencer
  always_comb
  begin
    next_mode = mode;
    case (mode)
      st_run:
        if (halt_exec_in && !rtc_interrupt_enable_in
          && !(watchdog_enabled_in && !watchdog_halt_option_in))  // [R11]
        begin
          if (timed_wake_enable)
            next_mode = st_timed_halt;  // [R1]
          else
            next_mode = st_plain_halt;  // [R16]
        end
      st_timed_halt:
        if (delay_done || halt_exit_irq_in)
          next_mode = st_stabilise;  // [R4] [R8]
      st_plain_halt:
        if (halt_exit_irq_in)
          next_mode = st_stabilise;  // [R8]
      st_stabilise:
        if (stab_count == stab_limit)
          next_mode = st_resume;  // [R5]
      st_resume:
        next_mode = st_run;
      default:
        next_mode = st_run;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      mode <= st_run;  // [R8]
    else
      mode <= next_mode;
  end

  // stabilisation counter, runs only while oscillator settles
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || mode != st_stabilise)
      stab_count <= 13'h0000;
    else
      stab_count <= stab_count + 13'h0001;  // [R5]
  end

  // ==========================================================
  // rc start-up and delay counting; restarted on every timed halt entry
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || mode != st_timed_halt)
    begin
      startup_count <= 16'h0000;
      rc_ready <= 1'b0;
      fixed_count <= 6'h00;
      prescale_count <= 8'h00;  // [R17]
    end
    else if (!rc_ready)
    begin
      startup_count <= startup_count + 16'h0001;
      if (startup_count == 16'(halt_wakeup_pkg::rc_startup_cycles - 1))
        rc_ready <= 1'b1;  // [R3]
    end
    else if (rc_rise)
    begin
      fixed_count <= fixed_count + 6'h01;  // [R2]
      if (fixed_count == 6'h3F)
        prescale_count <= prescale_count + 8'h01;  // [R2]
    end
  end

  // ==========================================================
  // control/status register
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      timed_wake_enable <= halt_wakeup_pkg::ctrl_status_reset[0];
      rc_measure_enable <= halt_wakeup_pkg::ctrl_status_reset[1];
    end
    else if (write_in && hit(addr_in, halt_wakeup_pkg::ctrl_status_offset))
    begin
      timed_wake_enable <= wdata_in[halt_wakeup_pkg::enable_bit];  // [R13]
      rc_measure_enable <= wdata_in[halt_wakeup_pkg::measure_bit];
    end
  end

  // flag: set wins over the clear-on-read
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      wake_event_flag <= halt_wakeup_pkg::ctrl_status_reset[2];
    else if (mode == st_timed_halt && delay_done)
      wake_event_flag <= 1'b1;  // [R4]
    else if (read_in && hit(addr_in, halt_wakeup_pkg::ctrl_status_offset))
      wake_event_flag <= 1'b0;  // [R6]
  end

  // prescaler ignores a zero write so the delay never collapses
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      wake_prescale_value <= halt_wakeup_pkg::prescaler_reset;  // [R14]
    else if (write_in && hit(addr_in, halt_wakeup_pkg::prescaler_offset)
      && wdata_in != 8'h00)
      wake_prescale_value <= wdata_in;  // [R14] [R15]
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      irq_mask <= halt_wakeup_pkg::irq_mask_reset;
    else if (write_in && hit(addr_in, halt_wakeup_pkg::irq_mask_offset))
      irq_mask <= {5'h00, wdata_in[2], 2'h0};
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || !read_in)
      rdata_out <= 8'h00;
    else if (hit(addr_in, halt_wakeup_pkg::ctrl_status_offset))
      rdata_out <= status_view;  // [R12]
    else if (hit(addr_in, halt_wakeup_pkg::prescaler_offset))
      rdata_out <= wake_prescale_value;
    else if (hit(addr_in, halt_wakeup_pkg::irq_mask_offset))
      rdata_out <= irq_mask;
    else
      rdata_out <= 8'h00;
  end

  // ==========================================================
  // outputs to cpu, oscillators and timer
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      irq_out <= 1'b0;
      main_osc_enable_out <= 1'b1;
      cpu_halted_out <= 1'b0;
      cpu_resume_out <= 1'b0;
      watchdog_reset_out <= 1'b0;
      force_mask_out <= 1'b0;
      rc_osc_enable_out <= 1'b0;
      timer_capture_input_one_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(status_view & irq_mask);  // [R4]
      main_osc_enable_out <= (next_mode != st_timed_halt)
        && (next_mode != st_plain_halt);  // [R10] [R5]
      cpu_halted_out <= (next_mode != st_run);
      cpu_resume_out <= (mode == st_resume);  // [R5]
      watchdog_reset_out <= (mode == st_run) && halt_exec_in
        && watchdog_enabled_in && !watchdog_halt_option_in;  // [R11]
      force_mask_out <= (mode == st_run) && (next_mode != st_run);  // [R9]
      rc_osc_enable_out <= (next_mode == st_timed_halt)
        || (next_mode == st_run && rc_measure_enable);  // [R2] [R7] [R17]
      timer_capture_input_one_out <= (mode == st_run) && rc_measure_enable
        && rc_level;  // [R7]
    end
  end

  assign condition_code_mask_out = halt_wakeup_pkg::halt_irq_mask;  // [R9]
endmodule : halt_wakeup

// *** testbench/halt_wakeup_checker.sv ***
`timescale 1ns/10ps
// ==========================================================
// port checks of the timed halt sequencer
module halt_wakeup_checker
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic read_in,
  input wire logic [7:0] rdata_out,
  input wire logic halt_exec_in,
  input wire logic rtc_interrupt_enable_in,
  input wire logic watchdog_enabled_in,
  input wire logic watchdog_halt_option_in,
  input wire logic halt_exit_irq_in,
  input wire logic main_osc_enable_out,
  input wire logic cpu_halted_out,
  input wire logic cpu_resume_out,
  input wire logic watchdog_reset_out,
  input wire logic force_mask_out,
  input wire logic [1:0] condition_code_mask_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  // halt entry is the rise of the halted level
  sequence s_enter;
    $rose(cpu_halted_out);
  endsequence
  a_entry_cause: assert property (s_enter |->
    $past(halt_exec_in) && !$past(rtc_interrupt_enable_in))
    else $error("halt entered without a halt request");
  a_osc_stopped: assert property (s_enter |-> !main_osc_enable_out)
    else $error("main oscillator running at halt entry");
  a_mask_pulse: assert property (s_enter |-> force_mask_out)
    else $error("mask not forced at halt entry");
  a_mask_value: assert property (condition_code_mask_out == 2'h2)
    else $error("forced mask value wrong");
  a_wdg_cause: assert property (watchdog_reset_out |->
    $past(halt_exec_in) && $past(watchdog_enabled_in)
    && !$past(watchdog_halt_option_in))
    else $error("watchdog reset without cause");
  a_wdg_no_halt: assert property (watchdog_reset_out |->
    !cpu_halted_out)
    else $error("halted together with watchdog reset");
  a_resume_pulse: assert property (cpu_resume_out |=> !cpu_resume_out)
    else $error("resume longer than one cycle");
  a_stab_before: assert property (cpu_resume_out |->
    $past(main_osc_enable_out, 16))
    else $error("resume before oscillator settled");
  a_exit_bound: assert property (cpu_halted_out && halt_exit_irq_in
    && !main_osc_enable_out |-> ##[1:600] !cpu_halted_out)
    else $error("exit interrupt did not end halt");
  a_read_window: assert property (!$past(read_in) |->
    rdata_out == 8'h00)
    else $error("read data outside its cycle");
endmodule : halt_wakeup_checker

bind halt_wakeup halt_wakeup_checker u_chk (.sys_clk_in(sys_clk_in),
  .reset_in(reset_in), .read_in(read_in), .rdata_out(rdata_out),
  .halt_exec_in(halt_exec_in),
  .rtc_interrupt_enable_in(rtc_interrupt_enable_in),
  .watchdog_enabled_in(watchdog_enabled_in),
  .watchdog_halt_option_in(watchdog_halt_option_in),
  .halt_exit_irq_in(halt_exit_irq_in),
  .main_osc_enable_out(main_osc_enable_out),
  .cpu_halted_out(cpu_halted_out), .cpu_resume_out(cpu_resume_out),
  .watchdog_reset_out(watchdog_reset_out),
  .force_mask_out(force_mask_out),
  .condition_code_mask_out(condition_code_mask_out));

// *** testbench/rc_osc_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// rc oscillator: 200 ns period, stands low while disabled
module rc_osc_model
(
  input wire logic enable_in,
  output logic rc_clk_out
);
  initial rc_clk_out = 1'b0;
  // edges fall on system clock falling edges, clear of the sampling edge
  always #100 rc_clk_out = enable_in ? ~rc_clk_out : 1'b0;
endmodule : rc_osc_model

// *** testbench/halt_wakeup_tb_top.sv ***
`timescale 1ns/10ps
module halt_wakeup_tb_top;
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, hx = 1'b0;
  logic [7:0] a = 8'h00, d = 8'h00, q;
  logic wde = 1'b0, wdo = 1'b1, xi = 1'b0, ls = 1'b0, rtc = 1'b0;
  logic irq, rce, cap, mo, hlt, wdr, rck;
  int errors = 0, num_checks = 0, cyc = 0, nw, ns;
  // ==========================================================
  // clock, hang guard, block and oscillator
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  halt_wakeup #(.stab_long_count(16)) DUT (.sys_clk_in(clk),
    .reset_in(rst), .addr_in(a), .wdata_in(d), .write_in(wr_s),
    .read_in(rd_s), .rdata_out(q), .irq_out(irq), .halt_exec_in(hx),
    .rtc_interrupt_enable_in(rtc), .watchdog_enabled_in(wde),
    .watchdog_halt_option_in(wdo), .halt_exit_irq_in(xi),
    .long_stab_in(ls), .rc_clk_in(rck), .rc_osc_enable_out(rce),
    .timer_capture_input_one_out(cap), .main_osc_enable_out(mo),
    .cpu_halted_out(hlt), .cpu_resume_out(), .watchdog_reset_out(wdr),
    .force_mask_out(), .condition_code_mask_out());
  rc_osc_model u_rc (.enable_in(rce), .rc_clk_out(rck));
  // ==========================================================
  // shared tasks
  task chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk) {a, d, wr_s} <= {ad, dt, 1'b1};
    @(posedge clk) wr_s <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk) {a, rd_s} <= {ad, 1'b1};
    @(posedge clk) rd_s <= 1'b0;
    #1 chk(q, e);
  endtask : rd
  // halt, then count cycles to oscillator restart and to resume
  task run_halt(input logic mid);
    nw = 0;
    ns = 0;
    @(posedge clk) hx <= 1'b1;
    @(posedge clk) hx <= 1'b0;
    #1 chk({hlt, mo, rce}, 3'h5);
    if (mid)
      @(posedge clk) xi <= 1'b1;
    #1;
    while (!mo && nw < 5000)
    begin
      @(posedge clk) #1 nw++;
    end
    while (hlt && ns < 5000)
    begin
      @(posedge clk) #1 ns++;
    end
    @(posedge clk) xi <= 1'b0;
  endtask : run_halt
  task wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // scenarios
  task t_regs();
    rd(8'h2B, 8'h00);
    rd(8'h2C, 8'hFF);
    rd(8'h30, 8'h00);
    wr(8'h2B, 8'hFF);
    rd(8'h2B, 8'h03);
    wr(8'h2C, 8'h00);
    rd(8'h2C, 8'hFF);
    wr(8'h2C, 8'h02);
    rd(8'h2C, 8'h02);
  endtask : t_regs
  task t_measure();
    logic seen;
    seen = 1'b0;
    wr(8'h2B, 8'h02);
    // look after the edge so the registered capture copy has settled
    repeat (40) @(posedge clk) #1 seen = seen | cap;
    chk({rce, seen}, 2'h3);
    wr(8'h2B, 8'h00);
    repeat (3) @(posedge clk);
    chk(rce, 1'b0);
  endtask : t_measure
  // prescaler 2 with 10-cycle rc period: 100 + 1280 cycles, less up to
  // one rc period because the first counted edge follows start-up freely
  task t_timed();
    wr(8'h2D, 8'h04);
    wr(8'h2B, 8'h01);
    run_halt(1'b0);
    chk(nw > 1369 && nw < 1382, 1'b1);
    chk(ns > 250 && ns < 262, 1'b1);
    chk({irq, rce}, 2'h2);
    rd(8'h2B, 8'h05);
    @(posedge clk) #1 chk(irq, 1'b0);
    rd(8'h2B, 8'h01);
  endtask : t_timed
  task t_exit();
    @(posedge clk) ls <= 1'b1;
    run_halt(1'b1);
    chk(ns > 12 && ns < 22, 1'b1);
    rd(8'h2B, 8'h01);
  endtask : t_exit
  // rtc irq enable set, then watchdog without halt option: halt must not enter the timed or plain halt here
  task t_wdg();
    @(posedge clk) rtc <= 1'b1;
    @(posedge clk) hx <= 1'b1;
    @(posedge clk) {hx, rtc} <= 2'h0;
    #1 chk({hlt, mo}, 2'h1);
    @(posedge clk) {wde, wdo} <= 2'h2;
    @(posedge clk) hx <= 1'b1;
    @(posedge clk) hx <= 1'b0;
    #1 chk({wdr, hlt}, 2'h2);
  endtask : t_wdg
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_measure();
    t_timed();
    t_exit();
    t_wdg();
    wrap_up();
  end
endmodule : halt_wakeup_tb_top
